//--- gsc_pkg.sv
// Purpose: shared constants for the pin, sync and calibration control bank
// Assumes: 8-bit register index, 16-bit register data
// Notes: offsets are the register indices used on the local register port
`default_nettype none

package gsc_pkg;

	// register port geometry
	localparam int GSC_AW = 8;
	localparam int GSC_DW = 16;

	// register offsets
	localparam logic [7:0] GSC_OFS_PIN_SYNC_CFG = 8'h4f;
	localparam logic [7:0] GSC_OFS_PIN_OUT_CAL = 8'h50;
	localparam logic [7:0] GSC_OFS_HOLD_GATE = 8'h5f;

	// values after reset, reserved fields at their defaults
	localparam logic [15:0] GSC_RST_PIN_SYNC_CFG = 16'h2090;
	localparam logic [15:0] GSC_RST_PIN_OUT_CAL = 16'h0000;
	localparam logic [15:0] GSC_RST_HOLD_GATE = 16'h0000;

	// field positions in the pin and sync configuration register
	localparam int GSC_BIT_PIN_B_OE = 6;
	localparam int GSC_BIT_PIN_B_IE = 5;
	localparam int GSC_BIT_SYNC_HI = 3;
	localparam int GSC_BIT_SYNC_LO = 2;
	localparam int GSC_BIT_PIN_A_IE = 1;

	// field positions in the output source and calibration register
	localparam int GSC_BIT_PIN_B_SRC = 6;
	localparam int GSC_BIT_CAL_START = 5;

	// field positions in the hold and clock gate register
	localparam int GSC_BIT_SLOT_B_HOLD = 2;
	localparam int GSC_BIT_SLOT_A_HOLD = 1;
	localparam int GSC_BIT_FAST_GATE = 0;

	// number of time slots with result freeze
	localparam int GSC_SLOTS = 2;

	// sample trigger source codes
	typedef enum logic [1:0] {
		GSC_TRIG_TIMER = 2'b00,
		GSC_TRIG_PIN_A = 2'b01,
		GSC_TRIG_PIN_B = 2'b10,
		GSC_TRIG_RSVD = 2'b11
	} gsc_trig_t;

endpackage : gsc_pkg

`default_nettype wire

//--- gsc_regs.sv
// Purpose: pin direction, sample trigger select, fast clock calibration
//   start and gate, and per-slot result freeze control bank
// Assumes: all inputs synchronous to i_mclk; register port driven by the
//   serial configuration front end of the device
// Notes: every output is registered, one cycle behind its cause
`default_nettype none

module gsc_regs
	import gsc_pkg::*;
(
	input wire logic i_mclk, // 50 MHz system clock
	input wire logic i_nrst, // synchronous reset, active low
	input wire logic i_wr_en, // register write strobe
	input wire logic i_rd_en, // register read strobe
	input wire logic [GSC_AW-1:0] i_addr, // register index
	input wire logic [GSC_DW-1:0] i_wr_data, // write data
	output logic [GSC_DW-1:0] o_rd_data, // read data, held until next read
	output logic o_rd_valid, // read data valid pulse
	input wire logic i_aux_pin_a_in, // pin A level from pad
	input wire logic i_aux_pin_b_in, // pin B level from pad
	output logic o_aux_pin_a_in_en, // pin A input buffer enable
	output logic o_aux_pin_b_in_en, // pin B input buffer enable
	output logic o_aux_pin_b_oe, // pin B output driver enable
	output logic o_aux_pin_b_out, // pin B output level
	input wire logic i_afe_pwrdn, // analog front end power-down
	input wire logic i_timer_tick, // divided 32 kHz sample tick
	output logic o_sample_start, // one-cycle sample cycle start
	output logic o_calib_start, // one-cycle ratio calculation start
	output logic o_fast_clock_gate, // fast clock enable level
	input wire logic i_slot_a_new, // slot A result ready to store
	input wire logic i_slot_b_new, // slot B result ready to store
	output logic o_slot_a_load, // slot A result register load pulse
	output logic o_slot_b_load // slot B result register load pulse
);

	// register file
	logic [GSC_DW-1:0] cfg_q, cfg_d; // pin and sync configuration
	logic [GSC_DW-1:0] ctl_q, ctl_d; // output source and calib start
	logic [GSC_DW-1:0] hold_q, hold_d; // slot hold and clock gate
	logic [GSC_DW-1:0] rd_data_d; // next read data
	logic rd_valid_d; // next read valid

	// register file next state: full words are stored, reserved bits too
	always_comb begin
		cfg_d = cfg_q;
		ctl_d = ctl_q;
		hold_d = hold_q;
		rd_data_d = o_rd_data;
		rd_valid_d = i_rd_en;
		if (i_wr_en) begin
			// unmapped writes are dropped silently
			case (i_addr)
				GSC_OFS_PIN_SYNC_CFG: cfg_d = i_wr_data;
				GSC_OFS_PIN_OUT_CAL: ctl_d = i_wr_data;
				GSC_OFS_HOLD_GATE: hold_d = i_wr_data;
				default: ;
			endcase
		end
		if (i_rd_en) begin
			// a read in the write cycle returns the old contents
			case (i_addr)
				GSC_OFS_PIN_SYNC_CFG: rd_data_d = cfg_q;
				GSC_OFS_PIN_OUT_CAL: rd_data_d = ctl_q;
				GSC_OFS_HOLD_GATE: rd_data_d = hold_q;
				default: rd_data_d = '0;
			endcase
		end
	end

	// register file flops
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			cfg_q <= GSC_RST_PIN_SYNC_CFG;
			ctl_q <= GSC_RST_PIN_OUT_CAL;
			hold_q <= GSC_RST_HOLD_GATE;
			o_rd_data <= '0;
			o_rd_valid <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			ctl_q <= ctl_d;
			hold_q <= hold_d;
			o_rd_data <= rd_data_d;
			o_rd_valid <= rd_valid_d;
		end
	end

	// pin control and sample trigger
	gsc_trig_t trig_src; // decoded trigger source
	logic pin_a_prev_q, pin_a_prev_d; // last pin A level
	logic pin_b_prev_q, pin_b_prev_d; // last pin B level
	logic start_d; // next sample start
	logic pin_a_ie_d, pin_b_ie_d, pin_b_oe_d, pin_b_out_d;

	assign trig_src = gsc_trig_t'(cfg_q[GSC_BIT_SYNC_HI:GSC_BIT_SYNC_LO]);

	// pads follow the new register value so a write shows one cycle later
	always_comb begin
		pin_a_prev_d = i_aux_pin_a_in;
		pin_b_prev_d = i_aux_pin_b_in;
		pin_b_oe_d = cfg_d[GSC_BIT_PIN_B_OE];
		pin_b_ie_d = cfg_d[GSC_BIT_PIN_B_IE];
		pin_a_ie_d = cfg_d[GSC_BIT_PIN_A_IE];
		// driven low unless the power-down source is chosen
		pin_b_out_d = pin_b_oe_d & ctl_d[GSC_BIT_PIN_B_SRC]
			& i_afe_pwrdn;
		// a pin trigger is a rising edge on an enabled input path; the timer tick level passes straight through
		case (trig_src)
			GSC_TRIG_TIMER: start_d = i_timer_tick;
			GSC_TRIG_PIN_A: start_d = cfg_q[GSC_BIT_PIN_A_IE]
				& i_aux_pin_a_in & ~pin_a_prev_q;
			GSC_TRIG_PIN_B: start_d = cfg_q[GSC_BIT_PIN_B_IE]
				& i_aux_pin_b_in & ~pin_b_prev_q;
			// reserved code: no trigger at all, safer than guessing
			default: start_d = 1'b0;
		endcase
	end

	// pin control flops
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			pin_a_prev_q <= 1'b0;
			pin_b_prev_q <= 1'b0;
			o_aux_pin_a_in_en <= 1'b0;
			o_aux_pin_b_in_en <= 1'b0;
			o_aux_pin_b_oe <= 1'b0;
			o_aux_pin_b_out <= 1'b0;
			o_sample_start <= 1'b0;
		end else begin
			pin_a_prev_q <= pin_a_prev_d;
			pin_b_prev_q <= pin_b_prev_d;
			o_aux_pin_a_in_en <= pin_a_ie_d;
			o_aux_pin_b_in_en <= pin_b_ie_d;
			o_aux_pin_b_oe <= pin_b_oe_d;
			o_aux_pin_b_out <= pin_b_out_d;
			o_sample_start <= start_d;
		end
	end

	// calibration start and fast clock gate
	logic cal_start_d; // next calibration start pulse
	logic gate_d; // next fast clock gate

	// only a 0 to 1 change starts; rewriting 1 does nothing
	always_comb begin
		cal_start_d = ctl_d[GSC_BIT_CAL_START]
			& ~ctl_q[GSC_BIT_CAL_START];
		gate_d = hold_d[GSC_BIT_FAST_GATE];
	end

	// calibration flops
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_calib_start <= 1'b0;
			o_fast_clock_gate <= 1'b0;
		end else begin
			o_calib_start <= cal_start_d;
			o_fast_clock_gate <= gate_d;
		end
	end

	// per-slot result freeze
	logic [GSC_SLOTS-1:0] slot_new; // index 0 slot A, 1 slot B
	logic [GSC_SLOTS-1:0] slot_hold; // current hold bits
	logic [GSC_SLOTS-1:0] load_q, load_d; // result load pulses

	assign slot_new = {i_slot_b_new, i_slot_a_new};
	assign slot_hold = {hold_q[GSC_BIT_SLOT_B_HOLD],
		hold_q[GSC_BIT_SLOT_A_HOLD]};

	// a result arriving while held is lost, not queued; keeps set coherent
	for (genvar s = 0; s < GSC_SLOTS; s++) begin : g_slot
		always_comb begin
			load_d[s] = slot_new[s] & ~slot_hold[s];
		end
		always_ff @(posedge i_mclk) begin
			if (!i_nrst) begin
				load_q[s] <= 1'b0;
			end else begin
				load_q[s] <= load_d[s];
			end
		end
	end

	assign o_slot_a_load = load_q[0];
	assign o_slot_b_load = load_q[1];

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	chk_pin_b_oe: assert property (
		i_wr_en && i_addr == GSC_OFS_PIN_SYNC_CFG
		|=> o_aux_pin_b_oe == $past(i_wr_data[GSC_BIT_PIN_B_OE]))
		else $error("pin B driver enable does not follow config");

	chk_pin_b_ie: assert property (
		i_wr_en && i_addr == GSC_OFS_PIN_SYNC_CFG
		|=> o_aux_pin_b_in_en == $past(i_wr_data[GSC_BIT_PIN_B_IE]))
		else $error("pin B input enable does not follow config");

	chk_pin_a_ie: assert property (
		i_wr_en && i_addr == GSC_OFS_PIN_SYNC_CFG
		|=> o_aux_pin_a_in_en == $past(i_wr_data[GSC_BIT_PIN_A_IE]))
		else $error("pin A input enable does not follow config");

	chk_timer_trig: assert property (
		trig_src == GSC_TRIG_TIMER
		|=> o_sample_start == $past(i_timer_tick))
		else $error("timer tick not passed as sample start");

	chk_pin_a_trig: assert property (
		trig_src == GSC_TRIG_PIN_A
		|=> o_sample_start == ($past(cfg_q[GSC_BIT_PIN_A_IE])
			&& $past(i_aux_pin_a_in) && !$past(i_aux_pin_a_in, 2)))
		else $error("pin A edge trigger wrong");

	chk_pin_b_trig: assert property (
		trig_src == GSC_TRIG_PIN_B || trig_src == GSC_TRIG_RSVD
		|=> o_sample_start == ($past(trig_src) == GSC_TRIG_PIN_B
			&& $past(cfg_q[GSC_BIT_PIN_B_IE])
			&& $past(i_aux_pin_b_in) && !$past(i_aux_pin_b_in, 2)))
		else $error("pin B or reserved trigger wrong");

	chk_pin_b_out: assert property (
		##1 o_aux_pin_b_out == (o_aux_pin_b_oe
			&& ctl_q[GSC_BIT_PIN_B_SRC] && $past(i_afe_pwrdn)))
		else $error("pin B output level wrong");

	chk_cal_start: assert property (
		o_calib_start |-> ctl_q[GSC_BIT_CAL_START]
			&& !$past(ctl_q[GSC_BIT_CAL_START]) ##1 !o_calib_start)
		else $error("calibration start without a fresh 0 to 1");

	chk_cal_fire: assert property (
		i_wr_en && i_addr == GSC_OFS_PIN_OUT_CAL
		&& i_wr_data[GSC_BIT_CAL_START] && !ctl_q[GSC_BIT_CAL_START]
		|=> o_calib_start)
		else $error("calibration start write ignored");

	chk_slot_b_hold: assert property (
		hold_q[GSC_BIT_SLOT_B_HOLD] |=> !o_slot_b_load)
		else $error("slot B loaded while held");

	chk_slot_a_load: assert property (
		i_slot_a_new && !hold_q[GSC_BIT_SLOT_A_HOLD] |=> o_slot_a_load)
		else $error("slot A result dropped while free");

	chk_fast_gate: assert property (
		i_wr_en && i_addr == GSC_OFS_HOLD_GATE
		|=> o_fast_clock_gate == $past(i_wr_data[GSC_BIT_FAST_GATE]))
		else $error("fast clock gate does not follow write");

	chk_read_back: assert property (
		i_rd_en && i_addr == GSC_OFS_PIN_SYNC_CFG
		|=> o_rd_valid && o_rd_data == $past(cfg_q))
		else $error("config read back wrong");

	chk_slot_a_hold: assert property (
		hold_q[GSC_BIT_SLOT_A_HOLD] |=> !o_slot_a_load)
		else $error("slot A loaded while held");

	chk_slot_b_load: assert property (
		i_slot_b_new && !hold_q[GSC_BIT_SLOT_B_HOLD] |=> o_slot_b_load)
		else $error("slot B result dropped while free");

	chk_pin_b_low: assert property (
		!ctl_q[GSC_BIT_PIN_B_SRC] |-> !o_aux_pin_b_out)
		else $error("pin B not low with low source");

	chk_cal_quiet: assert property (
		!(i_wr_en && i_addr == GSC_OFS_PIN_OUT_CAL) |=> !o_calib_start)
		else $error("calibration start without a write");

	chk_rd_pulse: assert property (
		##1 o_rd_valid == $past(i_rd_en))
		else $error("read valid not one cycle after strobe");

	chk_read_ctl: assert property (
		i_rd_en && i_addr == GSC_OFS_PIN_OUT_CAL
		|=> o_rd_data == $past(ctl_q))
		else $error("output source register read back wrong");

	chk_read_hold: assert property (
		i_rd_en && i_addr == GSC_OFS_HOLD_GATE
		|=> o_rd_data == $past(hold_q))
		else $error("hold register read back wrong");

endmodule : gsc_regs

`default_nettype wire

//--- gsc_host.sv
// Purpose: host side of the register port, word writes and reads
// Assumes: strobes change on the falling clock edge
// Notes: released lines show inverted values, never the last ones
`default_nettype none

module gsc_host
	import gsc_pkg::*;
(
	input wire logic i_mclk, // system clock
	input wire logic [GSC_DW-1:0] i_rd_data, // read data
	input wire logic i_rd_valid, // read data valid
	output logic o_wr_en, // write strobe
	output logic o_rd_en, // read strobe
	output logic [GSC_AW-1:0] o_addr, // register index
	output logic [GSC_DW-1:0] o_wr_data // write data
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle port at time zero
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wr_data = 16'h0000;
	end

	// one write; caller keeps reserved bits at defaults
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge i_mclk);
		o_wr_en = 1'b1;
		o_addr = a;
		o_wr_data = d;
		@(negedge i_mclk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wr_data = ~d;
	endtask : wr

	// read strobe, then a bounded wait for valid
	task automatic rd(input logic [7:0] a, output logic [15:0] d,
		output bit ok);
		int n;
		@(negedge i_mclk);
		o_rd_en = 1'b1;
		o_addr = a;
		@(negedge i_mclk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		ok = 1'b0;
		d = 16'h0000;
		for (n = 0; n < 4 && !ok; n++) begin
			if (i_rd_valid === 1'b1) begin
				ok = 1'b1;
				d = i_rd_data;
			end else
				@(negedge i_mclk);
		end
	endtask : rd

endmodule : gsc_host

`default_nettype wire

//--- gpio_sync_calib_ctrl_tb.sv
// Purpose: self-checking bench for the pin, sync and calibration bank
// Assumes: inputs change on the falling edge of a 50 MHz clock
// Notes: pulses are counted at rising edges, so no sampling race
`default_nettype none

module gpio_sync_calib_ctrl_tb
	import gsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic i_mclk = 1'b0; // clock
	logic i_nrst = 1'b0; // reset, active low
	logic wr_en, rd_en, rd_valid, pa, pb, pb_pad, a_ie, b_ie, b_oe, b_out;
	logic afe = 1'b0, tick = 1'b0, na = 1'b0, nb = 1'b0;
	logic s_start, c_start, gate, la, lb;
	logic [7:0] addr;
	logic [15:0] wd, rdat, v;
	int failures = 0, checked = 0, n_st = 0, n_ca = 0, n_la = 0, n_lb = 0;
	int seed, c, s;

	always #10 i_mclk = ~i_mclk;
	// pad level: the design drives pin B while its enable is high
	assign pb = b_oe ? b_out : pb_pad;

	// count output pulses, sampled before each edge updates them
	always @(posedge i_mclk) begin
		n_st += (s_start === 1'b1);
		n_ca += (c_start === 1'b1);
		n_la += (la === 1'b1);
		n_lb += (lb === 1'b1);
	end

	gsc_host host (.i_mclk(i_mclk), .i_rd_data(rdat), .i_rd_valid(rd_valid),
		.o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wd));

	gsc_regs uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wd), .o_rd_data(rdat),
		.o_rd_valid(rd_valid), .i_aux_pin_a_in(pa), .i_aux_pin_b_in(pb),
		.o_aux_pin_a_in_en(a_ie), .o_aux_pin_b_in_en(b_ie),
		.o_aux_pin_b_oe(b_oe), .o_aux_pin_b_out(b_out), .i_afe_pwrdn(afe),
		.i_timer_tick(tick), .o_sample_start(s_start),
		.o_calib_start(c_start), .o_fast_clock_gate(gate),
		.i_slot_a_new(na), .i_slot_b_new(nb), .o_slot_a_load(la),
		.o_slot_b_load(lb));

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (e !== g) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// starts from one pulse of source src under code cd; code 11 never
	function automatic logic [15:0] exp_start(input int cd, input int src);
		return (cd == src) ? 16'h0001 : 16'h0000;
	endfunction : exp_start

	// pin B level: driven only when enabled, follows the power-down level for the power-down source
	function automatic logic [15:0] exp_b_out(input logic oe,
		input logic src, input logic pd);
		return 16'(oe & src & pd);
	endfunction : exp_b_out

	// read a register and compare it
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		bit ok;
		host.rd(a, d, ok);
		if (!ok)
			chk("rd_valid", 16'h0001, 16'h0000);
		else
			chk("rd_data", e, d);
	endtask : rdchk

	// one trigger of source s: 0 timer, 1 pin A, 2 pin B
	task automatic fire(input int s);
		n_st = 0;
		tick = (s == 0);
		pa = (s == 1);
		pb_pad = (s == 2);
		@(negedge i_mclk);
		{tick, pa, pb_pad} = 3'b000;
		repeat (3) @(negedge i_mclk);
	endtask : fire

	task automatic give_verdict;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// hang guard, about 50000 cycles
	initial begin
		#1ms;
		failures++;
		give_verdict();
	end

	initial begin
		seed = 32'he5b70b7b;
		{pa, pb_pad} = 2'b00;
		repeat (12) @(negedge i_mclk);
		i_nrst = 1'b1;
		// reset values, then an unmapped index
		rdchk(GSC_OFS_PIN_SYNC_CFG, GSC_RST_PIN_SYNC_CFG);
		rdchk(GSC_OFS_PIN_OUT_CAL, GSC_RST_PIN_OUT_CAL);
		rdchk(GSC_OFS_HOLD_GATE, GSC_RST_HOLD_GATE);
		rdchk(8'h4e, 16'h0000);
		// a write to an unmapped index lands nowhere
		host.wr(8'h4e, 16'h0000);
		rdchk(GSC_OFS_PIN_SYNC_CFG, GSC_RST_PIN_SYNC_CFG);
		// random pin directions, reserved bits at defaults
		repeat (8) begin
			v = 16'h2090 | (16'($random(seed)) & 16'h0062);
			afe = 1'($random(seed));
			host.wr(GSC_OFS_PIN_SYNC_CFG, v);
			chk("pin_b_oe", 16'(v[6]), 16'(b_oe));
			chk("pin_b_ie", 16'(v[5]), 16'(b_ie));
			chk("pin_a_ie", 16'(v[1]), 16'(a_ie));
			rdchk(GSC_OFS_PIN_SYNC_CFG, v);
		end
		// every trigger code against every source
		for (c = 0; c < 4; c++)
			for (s = 0; s < 3; s++) begin
				v = 16'h20b2 | 16'(c << 2);
				host.wr(GSC_OFS_PIN_SYNC_CFG, v);
				fire(s);
				chk("start", exp_start(c, s), 16'(n_st));
			end
		// pin A edge with its input path off
		host.wr(GSC_OFS_PIN_SYNC_CFG, 16'h20b4);
		fire(1);
		chk("sample_start", 16'h0000, 16'(n_st));
		// pin B output: enable, source, power-down level
		for (c = 0; c < 8; c++) begin
			host.wr(GSC_OFS_PIN_SYNC_CFG, c[2] ? 16'h20d0 : 16'h2090);
			host.wr(GSC_OFS_PIN_OUT_CAL, 16'(c[1]) << 6);
			afe = c[0];
			repeat (2) @(negedge i_mclk);
			chk("pin_b_out", exp_b_out(c[2], c[1], c[0]), 16'(b_out));
		end
		// second start while set is ignored until cleared
		n_ca = 0;
		host.wr(GSC_OFS_PIN_OUT_CAL, 16'h0020);
		host.wr(GSC_OFS_PIN_OUT_CAL, 16'h0020);
		repeat (2) @(negedge i_mclk);
		chk("calib_start", 16'h0001, 16'(n_ca));
		host.wr(GSC_OFS_PIN_OUT_CAL, 16'h0000);
		host.wr(GSC_OFS_PIN_OUT_CAL, 16'h0020);
		repeat (2) @(negedge i_mclk);
		chk("calib_start", 16'h0002, 16'(n_ca));
		host.wr(GSC_OFS_HOLD_GATE, 16'h0001);
		chk("fast_gate", 16'h0001, 16'(gate));
		host.wr(GSC_OFS_HOLD_GATE, 16'h0000);
		chk("fast_gate", 16'h0000, 16'(gate));
		// both slots with every hold pattern
		for (c = 0; c < 4; c++) begin
			host.wr(GSC_OFS_HOLD_GATE, 16'(c << 1));
			n_la = 0;
			n_lb = 0;
			{na, nb} = 2'b11;
			@(negedge i_mclk);
			{na, nb} = 2'b00;
			repeat (3) @(negedge i_mclk);
			chk("slot_a_load", 16'(!c[0]), 16'(n_la));
			chk("slot_b_load", 16'(!c[1]), 16'(n_lb));
			rdchk(GSC_OFS_HOLD_GATE, 16'(c << 1));
		end
		give_verdict();
	end

endmodule : gpio_sync_calib_ctrl_tb

`default_nettype wire
